// ### pkg/ecp_pkg.sv
package ecp_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NUM_PINS = 6;
	localparam int PWM_TMR_W = 8;
	localparam int CAP_TMR_W = 16;
	localparam int DUTY_W = 10;
	localparam int DB_BITS = 7;
	localparam int TOSC_NS = 100;
	localparam int INSTR_NS = 400;
	localparam int INSTR_CYC = INSTR_NS / TOSC_NS;
	localparam logic [1:0] Q_LAST = 2'(INSTR_CYC - 1);
	// Register offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_PAIR_LO = 4'h1;
	localparam logic [3:0] OFF_PAIR_HI = 4'h2;
	localparam logic [3:0] OFF_PER2 = 4'h3;
	localparam logic [3:0] OFF_PER4 = 4'h4;
	localparam logic [3:0] OFF_DEAD = 4'h5;
	localparam logic [3:0] OFF_T3CTL = 4'h6;
	localparam logic [3:0] OFF_PINSET = 4'h7;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Control fields
	localparam int CFG_HI = 7;
	localparam int CFG_LO = 6;
	localparam int DLSB_HI = 5;
	localparam int DLSB_LO = 4;
	localparam logic [1:0] CFG_SINGLE = 2'h0;
	localparam logic [1:0] CFG_FWD = 2'h1;
	localparam logic [1:0] CFG_HALF = 2'h2;
	localparam logic [1:0] CFG_REV = 2'h3;
	localparam logic [1:0] PFX_PWM = 2'h3;
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] CMP_TOGGLE = 4'h2;
	localparam logic [3:0] CAP_FALL = 4'h4;
	localparam logic [3:0] CAP_RISE = 4'h5;
	localparam logic [3:0] CAP_RISE4 = 4'h6;
	localparam logic [3:0] CAP_RISE16 = 4'h7;
	localparam logic [3:0] CMP_SET = 4'h8;
	localparam logic [3:0] CMP_CLR = 4'h9;
	localparam logic [3:0] CMP_FLAG = 4'ha;
	localparam logic [3:0] CMP_TRIG = 4'hb;
	localparam logic [3:0] PRE4_LAST = 4'h3;
	localparam logic [3:0] PRE16_LAST = 4'hf;
	// Third timer control, pin setup and status bits
	localparam int TC_CAP_ON = 0;
	localparam int TC_PWM_ON = 1;
	localparam int TC_SEL = 3;
	localparam int PS_MAP = 0;
	localparam int PS_LARGE = 1;
	localparam int PS_MCU = 2;
	localparam int PS_E4ADR = 3;
	localparam int PS_E3ADR = 4;
	localparam int ST_FLAG = 0;
	localparam int ST_RUN = 1;
	// Pin indices
	localparam int PIN_G0 = 0;
	localparam int PIN_E4 = 1;
	localparam int PIN_E3 = 2;
	localparam int PIN_G3 = 3;
	localparam int PIN_H5 = 4;
	localparam int PIN_H4 = 5;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ecp_bus_t;

	typedef struct packed {
		logic [NUM_PINS-1:0] lvl;
		logic [NUM_PINS-1:0] own;
	} ecp_pins_t;

	typedef struct packed {
		logic [1:0] q;
		logic [DATA_W-1:0] ctrl;
		logic [DATA_W-1:0] plo;
		logic [DATA_W-1:0] phi;
		logic [DATA_W-1:0] tctl;
		logic [DATA_W-1:0] pset;
		logic cflag;
		logic [1:0][PWM_TMR_W-1:0] per;
		logic [1:0][PWM_TMR_W-1:0] ptmr;
		logic [1:0][CAP_TMR_W-1:0] t16;
		logic [DB_BITS-1:0] db_buf;
		logic [DB_BITS-1:0] db_act;
		logic db_pend;
		logic [DB_BITS-1:0] db_cnt;
		logic [DUTY_W-1:0] duty_act;
		logic [1:0] cfg_act;
		logic [1:0] pol_act;
		logic run;
		logic raw;
		logic [INSTR_CYC-1:0] shf;
		logic pd_prev;
		logic cmp_out;
		logic [3:0] cap_cnt;
		logic [1:0] cap_sync;
		logic cap_prev;
		ecp_pins_t pins;
		logic [DATA_W-1:0] rdata;
	} ecp_state_t;
endpackage

// ### rtl/ecp_core.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module ecp_core #(
	parameter int DB_W = ecp_pkg::DB_BITS
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Register port
	input wire ecp_pkg::ecp_bus_t bus_in,
	output logic [ecp_pkg::DATA_W-1:0] rdata_out,
	// Capture pin and neighbour unit
	input wire logic capture_pin_in,
	input wire logic nbr_out_in,
	input wire logic nbr_active_in,
	// Pin drive
	output ecp_pkg::ecp_pins_t pins_out
);
	import ecp_pkg::*;

	generate
		if (DB_W < 1 || DB_W > DB_BITS) begin : g_bad_db
			$error("DB_W out of range");
		end
	endgenerate

	localparam logic [DB_BITS-1:0] DB_MASK = DB_BITS'((1 << DB_W) - 1);

	function automatic logic is_pwm(input logic [DATA_W-1:0] c);
		return c[3:2] == PFX_PWM;
	endfunction

	function automatic logic is_quad(input logic [DATA_W-1:0] c);
		return is_pwm(c) && c[CFG_LO];
	endfunction

	function automatic logic is_dual(input logic [DATA_W-1:0] c);
		return is_pwm(c) && c[CFG_HI:CFG_LO] == CFG_HALF;
	endfunction

	ecp_state_t s;
	ecp_state_t next_s;
	logic ien;
	logic tsel;
	logic pwm_on;
	logic bnd;
	logic dmatch;
	logic trig;
	logic pd;
	logic [DUTY_W-1:0] duty_buf;

	assign ien = s.q == Q_LAST;
	assign tsel = s.tctl[TC_SEL];
	assign pwm_on = is_pwm(s.ctrl);
	assign bnd = ien && s.tctl[TC_PWM_ON] && s.ptmr[tsel] == s.per[tsel];
	// Looks one clock ahead, the output register adds that clock back
	assign dmatch = s.run && 10'({s.ptmr[tsel], s.q} + 10'h001) == s.duty_act;
	assign duty_buf = {s.plo, s.ctrl[DLSB_HI:DLSB_LO]};
	assign trig = ien && s.ctrl[3:0] == CMP_TRIG && s.t16[tsel] == {s.phi, s.plo};
	assign pd = s.shf[INSTR_CYC-1];

	always_comb begin
		logic [3:0] act;
		logic rise;
		logic fall;
		logic cap_ev;
		logic cmatch;
		logic ext;
		logic alt;
		logic dbok;
		act = 4'h0;
		rise = s.cap_sync[1] && !s.cap_prev;
		fall = !s.cap_sync[1] && s.cap_prev;
		cap_ev = 1'b0;
		cmatch = ien && s.ctrl[3] && !s.ctrl[2] && s.t16[tsel] == {s.phi, s.plo};
		ext = s.pset[PS_LARGE] && !s.pset[PS_MCU];
		alt = s.pset[PS_LARGE] && !s.pset[PS_MAP];
		// Dead band also covers the cycle in which the edge arrives
		dbok = (pd != s.pd_prev) ? (s.db_act == '0) : (s.db_cnt == '0);
		next_s = s;
		next_s.q = s.q + 2'h1;
		next_s.cap_sync = {s.cap_sync[0], capture_pin_in};
		next_s.cap_prev = s.cap_sync[1];
		// Time bases, second and fourth timers and both 16-bit timers
		for (int i = 0; i < 2; i++) begin
			if (ien && s.tctl[TC_PWM_ON]) begin
				if (s.ptmr[i] == s.per[i]) begin
					next_s.ptmr[i] = '0;
				end else begin
					next_s.ptmr[i] = s.ptmr[i] + 8'h01;
				end
			end
			if (ien && s.tctl[TC_CAP_ON]) begin
				next_s.t16[i] = s.t16[i] + 16'h0001;
			end
		end
		if (trig) begin
			next_s.t16[tsel] = '0;
		end
		// Dead-band reload
		if (s.db_pend && (bnd || dmatch)) begin
			next_s.db_act = s.db_buf;
			next_s.db_pend = 1'b0;
		end
		// Register writes
		if (bus_in.wr) begin
			case (bus_in.addr)
				OFF_CTRL: begin
					next_s.ctrl = bus_in.wdata;
				end
				OFF_PAIR_LO: begin
					next_s.plo = bus_in.wdata;
				end
				OFF_PAIR_HI: begin
					if (!pwm_on) begin
						next_s.phi = bus_in.wdata;
					end
				end
				OFF_PER2: begin
					next_s.per[0] = bus_in.wdata;
				end
				OFF_PER4: begin
					next_s.per[1] = bus_in.wdata;
				end
				OFF_DEAD: begin
					next_s.db_buf = bus_in.wdata[DB_BITS-1:0] & DB_MASK;
					next_s.db_pend = 1'b1;
				end
				OFF_T3CTL: begin
					next_s.tctl = bus_in.wdata;
				end
				OFF_PINSET: begin
					next_s.pset = bus_in.wdata;
				end
				OFF_STATUS: begin
					if (bus_in.wdata[ST_FLAG]) begin
						next_s.cflag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// PWM engine
		if (!pwm_on) begin
			next_s.run = 1'b0;
			next_s.raw = 1'b0;
		end else if (bnd) begin
			next_s.run = 1'b1;
			next_s.duty_act = duty_buf;
			next_s.phi = duty_buf[DUTY_W-1:2];
			next_s.cfg_act = s.ctrl[CFG_HI:CFG_LO];
			next_s.pol_act = s.ctrl[1:0];
			next_s.raw = duty_buf != '0;
		end else if (dmatch) begin
			next_s.raw = 1'b0;
		end
		next_s.shf = {s.shf[INSTR_CYC-2:0], s.raw};
		next_s.pd_prev = pd;
		if (pd != s.pd_prev) begin
			next_s.db_cnt = s.db_act;
		end else if (ien && s.db_cnt != '0) begin
			next_s.db_cnt = s.db_cnt - 7'h01;
		end
		// Capture and compare
		if (s.ctrl[3:2] == 2'h1) begin
			if ((s.ctrl[3:0] == CAP_RISE4 || s.ctrl[3:0] == CAP_RISE16) && rise) begin
				next_s.cap_cnt = s.cap_cnt + 4'h1;
			end
			case (s.ctrl[3:0])
				CAP_FALL: cap_ev = fall;
				CAP_RISE: cap_ev = rise;
				CAP_RISE4: cap_ev = rise && s.cap_cnt[1:0] == PRE4_LAST[1:0];
				CAP_RISE16: cap_ev = rise && s.cap_cnt == PRE16_LAST;
				default: cap_ev = 1'b0;
			endcase
		end else begin
			next_s.cap_cnt = '0;
		end
		if (cap_ev) begin
			{next_s.phi, next_s.plo} = s.t16[tsel];
			next_s.cflag = 1'b1;
		end
		if (ien && s.ctrl[3:0] == CMP_TOGGLE && s.t16[tsel] == {s.phi, s.plo}) begin
			next_s.cmp_out = !s.cmp_out;
			next_s.cflag = 1'b1;
		end
		if (cmatch) begin
			next_s.cflag = 1'b1;
			if (s.ctrl[3:0] == CMP_SET) begin
				next_s.cmp_out = 1'b1;
			end else if (s.ctrl[3:0] == CMP_CLR) begin
				next_s.cmp_out = 1'b0;
			end
		end
		// Output shaping per configuration
		if (s.run) begin
			case (s.cfg_act)
				CFG_SINGLE: act = {3'h0, s.raw};
				CFG_HALF: act = {2'h0, !pd && dbok, pd && dbok};
				CFG_FWD: act = {pd, 2'h0, 1'b1};
				CFG_REV: act = {1'b0, 1'b1, pd, 1'b0};
				default: act = 4'h0;
			endcase
		end
		// Pin routing
		next_s.pins.own = '0;
		next_s.pins.lvl = '0;
		if (pwm_on) begin
			next_s.pins.own[PIN_G0] = 1'b1;
			next_s.pins.lvl[PIN_G0] = act[0] ^ s.pol_act[1];
		end else if (s.ctrl[3:0] != MODE_OFF) begin
			next_s.pins.own[PIN_G0] = 1'b1;
			next_s.pins.lvl[PIN_G0] = s.cmp_out;
		end
		if (is_dual(s.ctrl) || is_quad(s.ctrl)) begin
			if (alt) begin
				next_s.pins.own[PIN_H5] = 1'b1;
				next_s.pins.lvl[PIN_H5] = act[1] ^ s.pol_act[0];
			end else if (!(ext && s.pset[PS_E4ADR])) begin
				next_s.pins.own[PIN_E4] = 1'b1;
				next_s.pins.lvl[PIN_E4] = act[1] ^ s.pol_act[0];
			end
		end
		if (is_quad(s.ctrl)) begin
			if (alt) begin
				next_s.pins.own[PIN_H4] = 1'b1;
				next_s.pins.lvl[PIN_H4] = act[2] ^ s.pol_act[1];
			end else if (!(ext && s.pset[PS_E3ADR])) begin
				next_s.pins.own[PIN_E3] = 1'b1;
				next_s.pins.lvl[PIN_E3] = act[2] ^ s.pol_act[1];
			end
			next_s.pins.own[PIN_G3] = 1'b1;
			next_s.pins.lvl[PIN_G3] = nbr_active_in ? nbr_out_in : act[3] ^ s.pol_act[0];
		end
		// Read port, pins left clear stay with port logic
		next_s.rdata = '0;
		if (bus_in.rd) begin
			case (bus_in.addr)
				OFF_CTRL: next_s.rdata = s.ctrl;
				OFF_PAIR_LO: next_s.rdata = s.plo;
				OFF_PAIR_HI: next_s.rdata = s.phi;
				OFF_PER2: next_s.rdata = s.per[0];
				OFF_PER4: next_s.rdata = s.per[1];
				OFF_DEAD: next_s.rdata = {1'b0, s.db_buf};
				OFF_T3CTL: next_s.rdata = s.tctl;
				OFF_PINSET: next_s.rdata = s.pset;
				OFF_STATUS: next_s.rdata = {6'h00, s.run, s.cflag};
				default: next_s.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rdata_out = s.rdata;
	assign pins_out = s.pins;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_period_end;
		bnd && pwm_on;
	endsequence

	sequence s_nonzero_end;
		s_period_end ##0 (duty_buf != '0);
	endsequence

	sequence s_zero_end;
		s_period_end ##0 (duty_buf == '0);
	endsequence

	AST_CFG_LOAD: assert property (s_period_end |=> s.cfg_act == $past(s.ctrl[CFG_HI:CFG_LO]))
		else $error("configuration not loaded at boundary");
	AST_HOLD: assert property (!bnd |=> $stable(s.duty_act))
		else $error("duty changed away from boundary");
	AST_SET: assert property (s_nonzero_end |=> s.raw && s.run)
		else $error("output not set at period start");
	AST_ZERO: assert property (s_zero_end |=> !s.raw ##1 !s.raw)
		else $error("zero duty set the output");
	AST_PERIOD: assert property (bnd |=> s.ptmr[$past(tsel)] == '0)
		else $error("time base not cleared at period");
	AST_TRIG: assert property (trig && !bus_in.wr |=> s.t16[$past(tsel)] == '0)
		else $error("special trigger did not clear timer");
	AST_LAG: assert property (pd == $past(s.raw, 4))
		else $error("enhanced output lag is not one instruction");
	AST_DEAD: assert property (s.db_pend && (bnd || dmatch) |=> s.db_act == $past(s.db_buf))
		else $error("dead band not loaded at boundary");
	AST_DB_EDGE: assert property (pwm_on && s.run && s.cfg_act == CFG_HALF && pd != s.pd_prev
		&& s.db_act != '0 |=> pins_out.lvl[PIN_G0] == $past(s.pol_act[1]))
		else $error("dead band let an edge through");
	AST_OVERRIDE: assert property (is_quad(s.ctrl) && nbr_active_in
		|=> pins_out.lvl[PIN_G3] == $past(nbr_out_in))
		else $error("neighbour unit did not override");
	AST_FREE: assert property (!pwm_on |=> pins_out.own[NUM_PINS-1:1] == '0)
		else $error("unassigned pin claimed");
endmodule

// ### sim/ecp_drive_model.sv
`timescale 1ns/1ps
module ecp_drive_model (
	// Clock
	input wire logic clk_in,
	// Pins from the unit
	input wire ecp_pkg::ecp_pins_t pins_in,
	// Bench controls
	input wire logic nbr_en_in,
	input wire logic cap_lvl_in,
	// Back to the unit, and the overlap flag to the bench
	output logic capture_out,
	output logic nbr_level_out,
	output logic nbr_active_out,
	output logic overlap_out
);
	import ecp_pkg::*;
	logic [1:0] phase = 2'h0;
	logic [NUM_PINS-1:0] driven;
	logic seen = 1'b0;
	// Neighbour unit: one clock high in four
	always_ff @(posedge clk_in) begin
		phase <= phase + 2'h1;
		if (driven[PIN_G0] && driven[PIN_E4]) begin
			seen <= 1'b1;
		end
	end
	assign nbr_level_out = (phase == 2'h0);
	assign nbr_active_out = nbr_en_in;
	assign capture_out = cap_lvl_in;
	// Switches see only owned pins; software set their direction
	assign driven = pins_in.lvl & pins_in.own;
	assign overlap_out = seen;
endmodule

// ### sim/tb_ecp_core.sv
`timescale 1ns/1ps
module tb_ecp_core;
	import ecp_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	ecp_bus_t bus_in = '0;
	logic [DATA_W-1:0] rdata_out;
	ecp_pins_t pins_out;
	logic cap_w;
	logic nbr_o;
	logic nbr_a;
	logic overlap;
	logic nbr_en = 1'b0;
	logic cap_lvl = 1'b0;
	int n_errors = 0;
	int samples_checked = 0;
	logic [7:0] cf_c [8] = '{8'h8c, 8'h4c, 8'hcc, 8'h8c, 8'h4c, 8'h4c, 8'h4c, 8'h0c};
	logic [7:0] cf_p [8] = '{8'h07, 8'h07, 8'h07, 8'h06, 8'h06, 8'h0b, 8'h05, 8'h07};
	logic [5:0] cf_o [8] = '{6'h03, 6'h0f, 6'h0f, 6'h11, 6'h39, 6'h0d, 6'h0f, 6'h01};
	logic [7:0] br_c [8] = '{8'h5c, 8'h5c, 8'h5f, 8'h5f, 8'hdc, 8'hdc, 8'h9c, 8'h9c};
	int br_p [8] = '{PIN_G0, PIN_G3, PIN_G0, PIN_G3, PIN_E3, PIN_E4, PIN_G0, PIN_E4};
	int br_n [8] = '{40, 10, 0, 30, 40, 10, 10, 30};
	always #50 clk_in = ~clk_in;
	ecp_core dut_u (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.bus_in(bus_in),
		.rdata_out(rdata_out),
		.capture_pin_in(cap_w),
		.nbr_out_in(nbr_o),
		.nbr_active_in(nbr_a),
		.pins_out(pins_out)
	);
	ecp_drive_model part_u (
		.clk_in(clk_in),
		.pins_in(pins_out),
		.nbr_en_in(nbr_en),
		.cap_lvl_in(cap_lvl),
		.capture_out(cap_w),
		.nbr_level_out(nbr_o),
		.nbr_active_out(nbr_a),
		.overlap_out(overlap)
	);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus_in.addr <= a;
		bus_in.wdata <= d;
		bus_in.wr <= 1'b1;
		@(posedge clk_in);
		bus_in.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		bus_in.addr <= a;
		bus_in.rd <= 1'b1;
		@(posedge clk_in);
		bus_in.rd <= 1'b0;
		#1;
		d = rdata_out;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		rd(a, d);
		chk({8'h00, d}, {8'h00, exp}, what);
	endtask
	// Settle past a boundary, then count high cycles over 40 clocks
	task automatic cnt(input int pin, input int exp, input string what);
		int n;
		n = 0;
		repeat (16) @(posedge clk_in);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_in);
			#1;
			n += int'(pins_out.lvl[pin] === 1'b1);
		end
		chk(16'(n), 16'(exp), what);
	endtask
	task automatic wait_flag(input int lim, input string what);
		logic [7:0] d;
		int k;
		d = 8'h00;
		k = 0;
		while (k < lim && d[ST_FLAG] !== 1'b1) begin
			rd(OFF_STATUS, d);
			k++;
		end
		chk({15'h0, d[ST_FLAG]}, 16'h1, what);
		if (d[ST_FLAG] !== 1'b1) begin
			complete_run();
		end
	endtask
	initial begin
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk({4'h0, pins_out.own, pins_out.lvl}, 16'h0, "reset pins");
		rdc(OFF_CTRL, 8'h00, "ctrl reset");
		rdc(4'hf, 8'h00, "unmapped");
		wr(OFF_CTRL, 8'ha5);
		rdc(OFF_CTRL, 8'ha5, "ctrl rw");
		wr(OFF_DEAD, 8'hff);
		rdc(OFF_DEAD, 8'h7f, "dead band");
		wr(OFF_DEAD, 8'h00);
		wr(OFF_PER2, 8'h00);
		wr(OFF_PINSET, 8'h07);
		wr(OFF_T3CTL, 8'h02);
		wr(OFF_PAIR_LO, 8'h00);
		wr(OFF_CTRL, 8'h2c);
		cnt(PIN_G0, 20, "single duty 2");
		rdc(OFF_STATUS, 8'h02, "running");
		wr(OFF_PAIR_LO, 8'h01);
		wr(OFF_CTRL, 8'h0c);
		cnt(PIN_G0, 40, "duty past period");
		rdc(OFF_PAIR_HI, 8'h01, "active duty");
		wr(OFF_PAIR_LO, 8'h00);
		cnt(PIN_G0, 0, "duty zero");
		wr(OFF_PER2, 8'h01);
		wr(OFF_CTRL, 8'h2c);
		cnt(PIN_G0, 10, "period 1");
		wr(OFF_PER4, 8'h00);
		wr(OFF_T3CTL, 8'h0a);
		cnt(PIN_G0, 20, "fourth timer base");
		wr(OFF_T3CTL, 8'h02);
		cnt(PIN_G0, 10, "second timer base");
		wr(OFF_PER2, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(OFF_PINSET, cf_p[i]);
			wr(OFF_CTRL, cf_c[i]);
			repeat (16) @(posedge clk_in);
			#1;
			chk({10'h0, pins_out.own}, {10'h0, cf_o[i]}, "pin owner");
		end
		wr(OFF_PINSET, 8'h07);
		for (int i = 0; i < 8; i++) begin
			wr(OFF_CTRL, br_c[i]);
			cnt(br_p[i], br_n[i], "bridge output");
		end
		wr(OFF_PER2, 8'h04);
		wr(OFF_DEAD, 8'h01);
		wr(OFF_PAIR_LO, 8'h02);
		wr(OFF_CTRL, 8'h8c);
		repeat (32) @(posedge clk_in);
		cnt(PIN_G0, 8, "dead band lead");
		cnt(PIN_E4, 16, "dead band trail");
		@(posedge clk_in);
		nbr_en <= 1'b1;
		wr(OFF_CTRL, 8'h6c);
		cnt(PIN_G3, 10, "neighbour override");
		@(posedge clk_in);
		nbr_en <= 1'b0;
		chk({15'h0, overlap}, 16'h0, "leg overlap");
		wr(OFF_CTRL, 8'h00);
		wr(OFF_T3CTL, 8'h01);
		wr(OFF_PAIR_LO, 8'h08);
		wr(OFF_PAIR_HI, 8'h00);
		wr(OFF_CTRL, 8'h0b);
		wr(OFF_STATUS, 8'h01);
		wait_flag(60, "trigger first");
		wr(OFF_STATUS, 8'h01);
		wait_flag(30, "trigger period");
		wr(OFF_CTRL, 8'h05);
		wr(OFF_STATUS, 8'h01);
		cap_lvl <= 1'b1;
		wait_flag(10, "capture rise");
		complete_run();
	end
endmodule
